// ===== src/pwm_gen_pkg.sv
// Package with register map, field layout and encodings of the PWM generator.
package pwm_gen_pkg;
    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_SYNC = 8'h04;
    localparam logic [7:0] OFF_ENABLE = 8'h08;
    localparam logic [7:0] OFF_CTL = 8'h40;
    localparam logic [7:0] OFF_EVSEL = 8'h44;
    localparam logic [7:0] OFF_STATUS = 8'h48;
    localparam logic [7:0] OFF_LOAD = 8'h50;
    localparam logic [7:0] OFF_COUNT = 8'h54;
    localparam logic [7:0] OFF_CMPA = 8'h58;
    localparam logic [7:0] OFF_CMPB = 8'h5C;
    localparam logic [7:0] OFF_ACTA = 8'h60;
    localparam logic [7:0] OFF_ACTB = 8'h64;
    localparam logic [7:0] OFF_DBCTL = 8'h68;
    localparam logic [7:0] OFF_DBRISE = 8'h6C;
    localparam logic [7:0] OFF_DBFALL = 8'h70;
    // ****************************************************************
    // Control, sync and event select fields, widths and reset value
    // ****************************************************************
    localparam int CTL_ENABLE = 0;
    localparam int CTL_UPDOWN = 1;
    localparam int CTL_GLOBAL = 2;
    localparam int CTL_AUXSYNC = 3;
    localparam int SYNC_GEN0 = 0;
    localparam int SYNC_GLOBAL_UPD = 8;
    localparam int EV_INT_LSB = 0;
    localparam int EV_ADC_LSB = 8;
    localparam int ACT_W = 2;
    localparam int NUM_EV = 6;
    localparam int CNT_W = 16;
    localparam int DB_W = 12;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    // ****************************************************************
    // Event order: zero, load, A up, A down, B up, B down
    // ****************************************************************
    localparam int EV_ZERO = 0;
    localparam int EV_LOAD = 1;
    localparam int EV_AUP = 2;
    localparam int EV_ADN = 3;
    localparam int EV_BUP = 4;
    localparam int EV_BDN = 5;
    typedef enum logic [1:0] {
        ACT_NONE = 2'h0,
        ACT_TOGGLE = 2'h1,
        ACT_LOW = 2'h2,
        ACT_HIGH = 2'h3
    } action_type;
endpackage : pwm_gen_pkg

// ===== src/pwm_deadband.sv
// Dead-band stage producing complementary delayed outputs.
`timescale 1ns/1ps
module pwm_deadband
    import pwm_gen_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic enable,
    input wire logic [DB_W-1:0] riseDelay,
    input wire logic [DB_W-1:0] fallDelay,
    input wire logic inA,
    input wire logic inB,
    output logic outA,
    output logic outB
);
    logic [DB_W-1:0] riseCount;
    logic [DB_W-1:0] fallCount;
    logic dbA;
    logic dbB;

    // Rise delay.
    // Counts saturate at the delay, so a long pulse cannot wrap them.
    always_ff @(posedge clock) begin
        if (srst || !inA) begin
            riseCount <= '0;
        end else if (riseCount < riseDelay) begin
            riseCount <= riseCount + 1'b1;
        end
    end
    assign dbA = riseCount >= riseDelay;

    always_ff @(posedge clock) begin
        if (srst || inA) begin
            fallCount <= '0;
        end else if (fallCount < fallDelay) begin
            fallCount <= fallCount + 1'b1;
        end
    end
    assign dbB = fallCount >= fallDelay;

    always_ff @(posedge clock) begin
        if (srst) begin
            outA <= 1'b0;
            outB <= 1'b0;
        end else if (enable) begin
            outA <= dbA && inA;
            outB <= dbB && !inA;
        end else begin
            outA <= inA;
            outB <= inB;
        end
    end
endmodule : pwm_deadband

// ===== src/pwm_generator_block.sv
// PWM generator with counter, comparators, actions, dead-band and APB.
`timescale 1ns/1ps
// Function
// - Down mode counts load to zero, then reloads load.
// - Up/down mode counts zero to load and back, repeating.
// - Direction low in down mode; high counting up in up/down.
// - One-cycle zero pulse at zero and load pulse at load.
// - In down mode load pulse follows zero pulse directly.
// - Comparators A and B pulse on match, split by direction.
// - Compare value above load never matches.
// - Four events in down mode, six in up/down mode.
// - Match events coinciding with zero or load are ignored.
// - Output A reacts to match A only, B to match B.
// - Per-event action: none, toggle, low or high.
// - Dead-band off passes through; on delays first output rise.
// - Second output inverts input with delayed rising edge.
// - Selected events raise the interrupt.
// - Separate selection raises the ADC trigger pulse.
// - Interrupt and trigger use raw events.
// - Sync bit write resets counter to zero.
// - Immediate mode registers act as written.
// - Local mode applies pending value at next zero.
// - Global mode applies after update bit then zero.
// - Load and compares update locally or globally per control bit.
// - Enable, actions and dead-band registers optionally synchronized.
// - Counter and load are 16 bits.
module pwm_generator_block
    import pwm_gen_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic firstOutput,
    output logic secondOutput,
    output logic interrupt,
    output logic adcTrigger,
    output logic direction
);
    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [31:0] ctl;
    logic [31:0] evSel;
    logic [CNT_W-1:0] loadAct, loadPend;
    logic [CNT_W-1:0] cmpAAct, cmpAPend;
    logic [CNT_W-1:0] cmpBAct, cmpBPend;
    logic [1:0] enAct, enPend;
    logic [11:0] actAAct, actAPend;
    logic [11:0] actBAct, actBPend;
    logic dbEnAct, dbEnPend;
    logic [DB_W-1:0] riseAct, risePend;
    logic [DB_W-1:0] fallAct, fallPend;
    logic globalArmed;
    logic [CNT_W-1:0] counter;
    logic up;
    logic genA, genB;
    logic [NUM_EV-1:0] events;
    logic dbOutA, dbOutB;

    logic wrEn, rdEn, mapped, syncHit;
    logic updateNow, auxUpdate;

    function automatic logic apply_action(input logic cur,
                                          input logic [1:0] act);
        unique case (action_type'(act))
            ACT_NONE: apply_action = cur;
            ACT_TOGGLE: apply_action = !cur;
            ACT_LOW: apply_action = 1'b0;
            ACT_HIGH: apply_action = 1'b1;
        endcase
    endfunction : apply_action

    function automatic logic wr_to(input logic [7:0] off);
        wr_to = wrEn && (paddr == off);
    endfunction : wr_to

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign pready = 1'b1;
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;
    always_comb begin
        unique case (paddr)
            OFF_SYNC, OFF_ENABLE, OFF_CTL, OFF_EVSEL, OFF_STATUS,
            OFF_LOAD, OFF_COUNT, OFF_CMPA, OFF_CMPB, OFF_ACTA,
            OFF_ACTB, OFF_DBCTL, OFF_DBRISE, OFF_DBFALL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;

    // Counter sync.
    // Written out: an assign does not wake on signals read inside a function.
    assign syncHit = wrEn && (paddr == OFF_SYNC) && pwdata[SYNC_GEN0];

    assign updateNow = events[EV_ZERO]
        && (!ctl[CTL_GLOBAL] || globalArmed);
    assign auxUpdate = !ctl[CTL_AUXSYNC] || updateNow;

    always_ff @(posedge clock) begin
        if (srst) begin
            globalArmed <= 1'b0;
        end else if (wr_to(OFF_SYNC) && pwdata[SYNC_GLOBAL_UPD]) begin
            globalArmed <= 1'b1;
        end else if (updateNow) begin
            globalArmed <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ctl <= RESET_VALUE;
            evSel <= RESET_VALUE;
        end else begin
            if (wr_to(OFF_CTL)) begin
                ctl <= {28'h000_0000, pwdata[3:0]};
            end
            if (wr_to(OFF_EVSEL)) begin
                evSel <= {16'h0000, 2'h0, pwdata[13:8], 2'h0, pwdata[5:0]};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            loadPend <= '0;
            cmpAPend <= '0;
            cmpBPend <= '0;
            loadAct <= '0;
            cmpAAct <= '0;
            cmpBAct <= '0;
        end else begin
            if (wr_to(OFF_LOAD)) begin
                loadPend <= pwdata[CNT_W-1:0];
            end
            if (wr_to(OFF_CMPA)) begin
                cmpAPend <= pwdata[CNT_W-1:0];
            end
            if (wr_to(OFF_CMPB)) begin
                cmpBPend <= pwdata[CNT_W-1:0];
            end
            if (updateNow || !ctl[CTL_ENABLE]) begin
                loadAct <= loadPend;
                cmpAAct <= cmpAPend;
                cmpBAct <= cmpBPend;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            enPend <= '0;
            actAPend <= '0;
            actBPend <= '0;
            dbEnPend <= 1'b0;
            risePend <= '0;
            fallPend <= '0;
            enAct <= '0;
            actAAct <= '0;
            actBAct <= '0;
            dbEnAct <= 1'b0;
            riseAct <= '0;
            fallAct <= '0;
        end else begin
            if (wr_to(OFF_ENABLE)) begin
                enPend <= pwdata[1:0];
            end
            if (wr_to(OFF_ACTA)) begin
                actAPend <= pwdata[11:0];
            end
            if (wr_to(OFF_ACTB)) begin
                actBPend <= pwdata[11:0];
            end
            if (wr_to(OFF_DBCTL)) begin
                dbEnPend <= pwdata[0];
            end
            if (wr_to(OFF_DBRISE)) begin
                risePend <= pwdata[DB_W-1:0];
            end
            if (wr_to(OFF_DBFALL)) begin
                fallPend <= pwdata[DB_W-1:0];
            end
            // Immediate path follows pending next cycle.
            if (auxUpdate) begin
                enAct <= enPend;
                actAAct <= actAPend;
                actBAct <= actBPend;
                dbEnAct <= dbEnPend;
                riseAct <= risePend;
                fallAct <= fallPend;
            end
        end
    end

    // ****************************************************************
    // Counter
    // ****************************************************************
    // Counter sequencing.
    always_ff @(posedge clock) begin
        if (srst || syncHit || !ctl[CTL_ENABLE]) begin
            counter <= '0;
            up <= 1'b1;
        end else if (!ctl[CTL_UPDOWN]) begin
            up <= 1'b0;
            counter <= (counter == 16'h0000) ? loadAct
                : counter - 16'h0001;
        end else if (up) begin
            if (counter >= loadAct) begin
                up <= 1'b0;
                counter <= (loadAct == 16'h0000) ? 16'h0000
                    : counter - 16'h0001;
            end else begin
                counter <= counter + 16'h0001;
            end
        end else if (counter == 16'h0000) begin
            up <= 1'b1;
            counter <= (loadAct == 16'h0000) ? 16'h0000 : 16'h0001;
        end else begin
            counter <= counter - 16'h0001;
        end
    end

    assign direction = ctl[CTL_UPDOWN] && up && ctl[CTL_ENABLE];

    always_comb begin
        events = '0;
        if (ctl[CTL_ENABLE]) begin
            events[EV_ZERO] = (counter == 16'h0000);
            events[EV_LOAD] = (counter == loadAct);
            if (cmpAAct <= loadAct && counter == cmpAAct) begin
                events[EV_AUP] = direction;
                events[EV_ADN] = !direction;
            end
            if (cmpBAct <= loadAct && counter == cmpBAct) begin
                events[EV_BUP] = direction;
                events[EV_BDN] = !direction;
            end
        end
    end

    // ****************************************************************
    // Signal generator
    // ****************************************************************
    // Zero/load override matches; A and B separate.
    always_ff @(posedge clock) begin
        if (srst || !ctl[CTL_ENABLE]) begin
            genA <= 1'b0;
            genB <= 1'b0;
        end else if (events[EV_ZERO] || events[EV_LOAD]) begin
            genA <= apply_action(
                apply_action(genA, events[EV_ZERO] ? actAAct[1:0] : 2'h0),
                events[EV_LOAD] ? actAAct[3:2] : 2'h0);
            genB <= apply_action(
                apply_action(genB, events[EV_ZERO] ? actBAct[1:0] : 2'h0),
                events[EV_LOAD] ? actBAct[3:2] : 2'h0);
        end else begin
            if (events[EV_AUP]) begin
                genA <= apply_action(genA, actAAct[5:4]);
            end else if (events[EV_ADN]) begin
                genA <= apply_action(genA, actAAct[7:6]);
            end
            if (events[EV_BUP]) begin
                genB <= apply_action(genB, actBAct[9:8]);
            end else if (events[EV_BDN]) begin
                genB <= apply_action(genB, actBAct[11:10]);
            end
        end
    end

    pwm_deadband deadband (
        .clock(clock),
        .srst(srst),
        .enable(dbEnAct),
        .riseDelay(riseAct),
        .fallDelay(fallAct),
        .inA(genA),
        .inB(genB),
        .outA(dbOutA),
        .outB(dbOutB)
    );

    assign firstOutput = dbOutA && enAct[0];
    assign secondOutput = dbOutB && enAct[1];

    // Interrupt and ADC trigger from raw events.
    always_ff @(posedge clock) begin
        if (srst) begin
            interrupt <= 1'b0;
            adcTrigger <= 1'b0;
        end else begin
            interrupt <= |(events & evSel[EV_INT_LSB +: NUM_EV]);
            adcTrigger <= |(events & evSel[EV_ADC_LSB +: NUM_EV]);
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata <= RESET_VALUE;
        end else if (rdEn && psel && !penable) begin
            prdata <= RESET_VALUE;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFF_ENABLE: prdata <= {30'h0, enPend};
                OFF_CTL: prdata <= ctl;
                OFF_EVSEL: prdata <= evSel;
                OFF_STATUS: prdata <= {29'h0, globalArmed, direction,
                                       ctl[CTL_ENABLE]};
                OFF_LOAD: prdata <= {16'h0000, loadPend};
                OFF_COUNT: prdata <= {16'h0000, counter};
                OFF_CMPA: prdata <= {16'h0000, cmpAPend};
                OFF_CMPB: prdata <= {16'h0000, cmpBPend};
                OFF_ACTA: prdata <= {20'h0_0000, actAPend};
                OFF_ACTB: prdata <= {20'h0_0000, actBPend};
                OFF_DBCTL: prdata <= {31'h0, dbEnPend};
                OFF_DBRISE: prdata <= {20'h0_0000, risePend};
                OFF_DBFALL: prdata <= {20'h0_0000, fallPend};
                default: prdata <= RESET_VALUE;
            endcase
        end
    end
endmodule : pwm_generator_block

// ===== test/pwm_gen_chk.sv
// Port checker for the PWM generator block.
`timescale 1ns/1ps
module pwm_gen_chk
    import pwm_gen_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic firstOutput,
    input wire logic secondOutput,
    input wire logic interrupt,
    input wire logic adcTrigger,
    input wire logic direction
);
    logic acc;
    logic mapped;
    logic everOn;
    logic upDown;
    logic dbOn;
    logic auxOn;
    logic [1:0] enBits;
    assign acc = psel && penable;
    assign mapped = paddr inside {OFF_SYNC, OFF_ENABLE, OFF_CTL, OFF_EVSEL,
        OFF_STATUS, OFF_LOAD, OFF_COUNT, OFF_CMPA, OFF_CMPB, OFF_ACTA,
        OFF_ACTB, OFF_DBCTL, OFF_DBRISE, OFF_DBFALL};
    // Mirror of immediate control bits; only valid while sync mode is off.
    always_ff @(posedge clock) begin
        if (srst) begin
            everOn <= 1'b0;
            upDown <= 1'b0;
            dbOn <= 1'b0;
            auxOn <= 1'b0;
            enBits <= 2'b00;
        end else if (acc && pwrite) begin
            if (paddr == OFF_CTL) begin
                everOn <= everOn || pwdata[CTL_ENABLE];
                upDown <= pwdata[CTL_UPDOWN];
                auxOn <= pwdata[CTL_AUXSYNC];
            end
            if (paddr == OFF_DBCTL) begin
                dbOn <= pwdata[0];
            end
            if (paddr == OFF_ENABLE) begin
                enBits <= pwdata[1:0];
            end
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    a_ready_high: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_error_flag: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr does not match the address map");
    a_unmapped_zero: assert property (
        acc && !pwrite && !mapped |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_count_width: assert property (
        acc && !pwrite && paddr == OFF_COUNT |-> prdata[31:16] == 16'h0000)
        else $error("counter wider than sixteen bits");
    a_idle_quiet: assert property (!everOn |->
        !firstOutput && !secondOutput && !interrupt && !adcTrigger)
        else $error("activity before the generator was enabled");
    a_mask_first: assert property (
        !auxOn && !enBits[0] && !$past(enBits[0])
        && !$past(enBits[0], 2) |-> !firstOutput)
        else $error("first output high while masked");
    a_mask_second: assert property (
        !auxOn && !enBits[1] && !$past(enBits[1])
        && !$past(enBits[1], 2) |-> !secondOutput)
        else $error("second output high while masked");
    // Four cycles let the write, the stage and the output register settle.
    a_no_overlap: assert property (
        dbOn && $past(dbOn, 4) |-> !(firstOutput && secondOutput))
        else $error("both outputs high with dead band on");
    a_down_dir: assert property (
        !upDown && !$past(upDown) && !$past(upDown, 2) |-> !direction)
        else $error("direction high in down mode");
endmodule : pwm_gen_chk
bind pwm_generator_block pwm_gen_chk u_pwm_gen_chk (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .firstOutput(firstOutput),
    .secondOutput(secondOutput), .interrupt(interrupt),
    .adcTrigger(adcTrigger), .direction(direction)
);

// ===== test/pwm_drive_model.sv
// Gate driver pair and converter trigger input driven by the block.
`timescale 1ns/1ps
module pwm_drive_model (
    input wire logic clock,
    input wire logic gateHigh,
    input wire logic gateLow,
    input wire logic adcTrigger,
    output int triggerCount,
    output int overlapCount
);
    initial begin
        triggerCount = 0;
        overlapCount = 0;
    end
    always @(negedge clock) begin
        // One conversion starts per trigger pulse.
        if (adcTrigger === 1'b1) begin
            triggerCount <= triggerCount + 1;
        end
        // Both gates on would short the half bridge.
        if (gateHigh === 1'b1 && gateLow === 1'b1) begin
            overlapCount <= overlapCount + 1;
        end
    end
endmodule : pwm_drive_model

// ===== test/pwm_generator_block_test.sv
// Self-checking bench for the PWM generator block.
`timescale 1ns/1ps
module pwm_generator_block_test
    import pwm_gen_pkg::*;
;
    logic clock;
    logic srst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic firstOutput;
    logic secondOutput;
    logic interrupt;
    logic adcTrigger;
    logic direction;
    int triggerCount;
    int overlapCount;
    int miscompares = 0;
    int comparisons = 0;
    logic [31:0] q;
    logic e;
    int n, h1, h2, ints, adcs, dirs, ovl;
    pwm_generator_block u_pwm_generator_block (
        .clock(clock), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .firstOutput(firstOutput),
        .secondOutput(secondOutput), .interrupt(interrupt),
        .adcTrigger(adcTrigger), .direction(direction)
    );
    pwm_drive_model u_pwm_drive_model (
        .clock(clock), .gateHigh(firstOutput), .gateLow(secondOutput),
        .adcTrigger(adcTrigger), .triggerCount(triggerCount),
        .overlapCount(overlapCount)
    );
    task automatic report_and_stop;
        $display("%0d mismatches, %0d comparisons", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    task automatic give_up;
        miscompares++;
        $display("wrong value at %0t: wait ran out", $time);
        report_and_stop();
    endtask : give_up
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h, want %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            give_up();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // The count includes the cycle of the interrupt pulse itself.
    task automatic waitInt(output int c);
        c = 0;
        do begin
            @(negedge clock);
            c++;
        end while (interrupt !== 1'b1 && c < 200);
        if (interrupt !== 1'b1) begin
            give_up();
        end
    endtask : waitInt
    // A window of one whole period sees each event once in any phase.
    task automatic measure(input int len);
        int t;
        t = triggerCount;
        ovl = overlapCount;
        h1 = 0;
        h2 = 0;
        ints = 0;
        dirs = 0;
        repeat (len) begin
            @(negedge clock);
            h1 += (firstOutput === 1'b1);
            h2 += (secondOutput === 1'b1);
            ints += (interrupt === 1'b1);
            dirs += (direction === 1'b1);
        end
        adcs = triggerCount - t;
        ovl = overlapCount - ovl;
    endtask : measure
    task automatic s_reset;
        logic [7:0] offs [13] = '{OFF_ENABLE, OFF_CTL, OFF_EVSEL, OFF_STATUS,
            OFF_LOAD, OFF_COUNT, OFF_CMPA, OFF_CMPB, OFF_ACTA, OFF_ACTB,
            OFF_DBCTL, OFF_DBRISE, OFF_DBFALL};
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 32'h0000_0000);
            check(q, RESET_VALUE);
        end
        apb(1'b0, 8'hFC, 32'h0000_0000);
        check(q, 32'h0000_0000);
        check(e, 1'b1);
    endtask : s_reset
    task automatic s_down;
        apb(1'b1, OFF_LOAD, 32'h0000_0009);
        apb(1'b1, OFF_CMPA, 32'h0000_0004);
        apb(1'b1, OFF_CMPB, 32'h0000_000C);
        apb(1'b1, OFF_ACTA, 32'h0000_0083);
        apb(1'b1, OFF_ACTB, 32'h0000_0C00);
        apb(1'b1, OFF_EVSEL, 32'h0000_0801);
        apb(1'b1, OFF_ENABLE, 32'h0000_0003);
        apb(1'b1, OFF_CTL, 32'h0000_0001);
        waitInt(n);
        waitInt(n);
        check(n, 10);
        measure(10);
        check(h1, 6);
        check(h2, 0);
        check(ints, 1);
        check(adcs, 1);
        apb(1'b1, OFF_ACTA, 32'h0000_0001);
        waitInt(n);
        measure(20);
        check(h1, 10);
    endtask : s_down
    task automatic s_updown;
        apb(1'b1, OFF_ACTA, 32'h0000_00B0);
        apb(1'b1, OFF_CTL, 32'h0000_0003);
        waitInt(n);
        waitInt(n);
        check(n, 18);
        measure(18);
        check(h1, 10);
        check(dirs, 9);
        check(adcs, 1);
    endtask : s_updown
    task automatic s_local;
        waitInt(n);
        apb(1'b1, OFF_LOAD, 32'h0000_0004);
        waitInt(n);
        check(n > 10, 1'b1);
        waitInt(n);
        check(n, 8);
        measure(8);
        check(h1, 0);
        apb(1'b0, OFF_LOAD, 32'h0000_0000);
        check(q, 32'h0000_0004);
    endtask : s_local
    task automatic s_global;
        apb(1'b1, OFF_CTL, 32'h0000_0007);
        apb(1'b1, OFF_LOAD, 32'h0000_0009);
        waitInt(n);
        waitInt(n);
        check(n, 8);
        apb(1'b1, OFF_SYNC, 32'h0000_0100);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        check(q[2], 1'b1);
        waitInt(n);
        waitInt(n);
        check(n, 18);
    endtask : s_global
    task automatic s_sync;
        waitInt(n);
        repeat (3) @(negedge clock);
        apb(1'b1, OFF_SYNC, 32'h0000_0001);
        apb(1'b0, OFF_COUNT, 32'h0000_0000);
        check(q < 4, 1'b1);
    endtask : s_sync
    task automatic s_deadband;
        apb(1'b1, OFF_CTL, 32'h0000_0001);
        apb(1'b1, OFF_ACTA, 32'h0000_0083);
        apb(1'b1, OFF_DBRISE, 32'h0000_0002);
        apb(1'b1, OFF_DBFALL, 32'h0000_0003);
        apb(1'b1, OFF_DBCTL, 32'h0000_0001);
        waitInt(n);
        waitInt(n);
        check(n, 10);
        measure(10);
        check(h1, 4);
        check(h2, 1);
        check(ovl, 0);
        check(adcs, 1);
        apb(1'b1, OFF_CTL, 32'h0000_0009);
        waitInt(n);
        apb(1'b1, OFF_ENABLE, 32'h0000_0000);
        measure(4);
        check(h1, 4);
        waitInt(n);
        measure(10);
        check(h1 + h2, 0);
    endtask : s_deadband
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        s_reset();
        s_down();
        s_updown();
        s_local();
        s_global();
        s_sync();
        s_deadband();
        report_and_stop();
    end
endmodule : pwm_generator_block_test
